/* verilog/power_good_monitor.sv */
// power-good aggregation and diagnostic interrupt logic
// assumes asynchronous comparator flags and same-clock sequencer inputs
//
// Overview of operation
// - each buck and ldo rail can be selected as a power-good source
// - a disabled regulator never pulls power-good inactive
// - thermal warning can be selected as a power-good source
// - power-good needs selected rails valid, no warning, no ov or shutdown irq
// - window bit 0 checks undervoltage only, 1 checks both limits
// - software picks pin polarity and push-pull or open-drain
// - mode bit 0 gated, 1 continuous; initial value from otp
// - power-good asserts when the otp load finishes
// - gated mode freezes power-good 800 us after sequencing or voltage change
// - gated mode latches rail faults and holds power-good low until cleared
// - continuous mode drops power-good when a monitored regulator enables
// - continuous mode follows regulation status with no gating window
// - rail fault bits stay set until written with 1
// - continuous mode holds power-good low while a monitored rail ramps
// - fault-hold bit keeps power-good low while any rail fault pends
// - each buck has a 3-bit peak current limit select
// - buck in current limit 20 us sets its irq and pulls irq pin low
// - ldo in current limit 20 us sets its irq and pulls irq pin low
// - live limit status, write-1 clear, mask bit keeps the irq off the irq pin
// - a config bit picks the thermal warning threshold
// - thermal warning sets irq, live status, write-1 clear and mask
// - write-1 clear is refused while the limit condition persists
// - polarity only affects the pin; internal status is active-high
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps

`include "pg_consts.svh"

module power_good_monitor #(
    parameter int GATE_CYCLES = `PG_GATE_TIME_US * `PG_CLOCK_MHZ
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire pg_pkg::reg_req_t bus_req,
    output logic [7:0]            bus_rdata,
    input  wire pg_pkg::sense_t   sense_raw,
    input  wire logic [3:0]       rail_enable,
    input  wire logic [3:0]       rail_ramping,
    input  wire logic             volt_change_req,
    input  wire logic             otp_load_done,
    input  wire logic             otp_pg_mode,
    output logic [2:0]            buck0_limit_sel,
    output logic [2:0]            buck1_limit_sel,
    output logic                  die_warn_threshold,
    output logic                  power_good_out,
    output logic                  power_good_oe,
    output logic                  irq_out_n
);

    localparam int LIMIT_CYCLES = `PG_LIMIT_TIME_US * `PG_CLOCK_MHZ;
    localparam int SW           = $bits(pg_pkg::sense_t);

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [SW-1:0]         sync1;
    logic [SW-1:0]         sync2;
    logic [SW-1:0]         sync3;
    logic [SW-1:0]         sense_f;
    pg_pkg::sense_t        sense;

    // a change is taken only once the second and third stages agree
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1   <= '0;
            sync2   <= '0;
            sync3   <= '0;
            sense_f <= '0;
        end else begin
            sync1   <= sense_raw;
            sync2   <= sync1;
            sync3   <= sync2;
            sense_f <= (sync2 & sync3) | (sense_f & (sync2 ^ sync3));
        end
    end

    assign sense = sense_f;

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [4:0]            pg_select;
    logic [3:0]            pg_window_sel;
    logic [3:0]            pg_cfg;
    logic [3:0]            rail_fault_latch;
    logic [7:0]            limit_sel;
    logic [6:0]            irq;
    logic [4:0]            irq_mask;
    logic                  pg_state;
    pg_pkg::pg_phase_t     phase;
    pg_pkg::pg_mode_t      mode;
    logic                  wr_sel;
    logic                  wr_win;
    logic                  wr_cfg;
    logic                  wr_lim;
    logic                  wr_mask;
    logic                  wr_conf;
    logic [3:0]            fault_clr;
    logic [6:0]            irq_clr;

    assign wr_sel    = bus_req.wr && bus_req.addr == `PG_ADDR_SELECT;
    assign wr_win    = bus_req.wr && bus_req.addr == `PG_ADDR_WINDOW;
    assign wr_cfg    = bus_req.wr && bus_req.addr == `PG_ADDR_CFG;
    assign wr_lim    = bus_req.wr && bus_req.addr == `PG_ADDR_LIMIT_SEL;
    assign wr_mask   = bus_req.wr && bus_req.addr == `PG_ADDR_MASK;
    assign wr_conf   = bus_req.wr && bus_req.addr == `PG_ADDR_CONFIG;
    assign fault_clr = (bus_req.wr && bus_req.addr == `PG_ADDR_FAULT) ?
                       bus_req.wdata[3:0] : 4'h0;
    assign irq_clr   = (bus_req.wr && bus_req.addr == `PG_ADDR_IRQ) ?
                       bus_req.wdata[6:0] : 7'h00;

    always_ff @(posedge clock) begin
        if (rst) begin
            pg_select          <= `PG_SELECT_RESET;
            pg_window_sel      <= `PG_WINDOW_RESET;
            limit_sel          <= `PG_LIMIT_RESET;
            irq_mask           <= `PG_MASK_RESET;
            die_warn_threshold <= 1'b0;
        end else begin
            if (wr_sel)
                pg_select <= bus_req.wdata[4:0];
            if (wr_win)
                pg_window_sel <= bus_req.wdata[3:0];
            if (wr_lim)
                limit_sel <= bus_req.wdata;
            if (wr_mask)
                irq_mask <= bus_req.wdata[4:0];
            if (wr_conf)
                die_warn_threshold <= bus_req.wdata[0];
        end
    end

    // mode bit is seeded from otp at load end, software may change it later
    always_ff @(posedge clock) begin
        if (rst) begin
            pg_cfg <= `PG_CFG_RESET;
        end else if (otp_load_done) begin
            pg_cfg[`PG_CFG_MODE] <= otp_pg_mode;
        end else if (wr_cfg) begin
            pg_cfg <= bus_req.wdata[3:0];
        end
    end

    assign mode            = pg_pkg::pg_mode_t'(pg_cfg[`PG_CFG_MODE]);
    assign buck0_limit_sel = limit_sel[2:0];
    assign buck1_limit_sel = limit_sel[6:4];

    ////////////////////////////////////////////////////////////////////////////////
    // current limit and thermal warning qualification

    logic [4:0]            qual_cond;
    logic [4:0]            qualified;
    logic [6:0]            irq_active;
    logic [6:0]            irq_set;

    assign qual_cond = {sense.die_warn, sense.limit};

    genvar ch;
    generate
        for (ch = 0; ch < 5; ch++) begin : gen_qual
            logic [12:0] cnt;
            always_ff @(posedge clock) begin
                if (rst || !qual_cond[ch])
                    cnt <= 13'h0000;
                else if (cnt != 13'(LIMIT_CYCLES - 1))
                    cnt <= cnt + 13'h0001;
            end
            assign qualified[ch] = qual_cond[ch] && cnt == 13'(LIMIT_CYCLES - 1);
        end
    endgenerate

    assign irq_set    = {sense.die_sd, sense.vana_ov, qualified};
    assign irq_active = {sense.die_sd, sense.vana_ov, qualified};

    // a set in the clearing cycle wins; clears are refused while active
    always_ff @(posedge clock) begin
        if (rst)
            irq <= 7'h00;
        else
            irq <= (irq & ~(irq_clr & ~irq_active)) | irq_set;
    end

    // ov and shutdown interrupts have no mask
    always_ff @(posedge clock) begin
        if (rst)
            irq_out_n <= 1'b1;
        else
            irq_out_n <= ~|(irq & {2'b11, ~irq_mask});
    end

    ////////////////////////////////////////////////////////////////////////////////
    // rail monitoring

    logic [3:0]            rail_ok;
    logic [3:0]            monitored;
    logic [3:0]            enable_q;
    logic [3:0]            enable_rise;
    logic [3:0]            fault_set;
    logic                  fault_armed;
    logic                  sources_ok;
    logic                  die_warn_status;

    assign rail_ok         = sense.uv_ok & (~pg_window_sel | sense.ov_ok);
    assign monitored       = pg_select[3:0] & rail_enable;
    assign enable_rise     = monitored & ~enable_q;
    assign die_warn_status = qualified[4];
    assign fault_armed     = (mode == pg_pkg::PG_GATED) ? (phase == pg_pkg::PG_WATCH) :
                             (phase != pg_pkg::PG_IDLE);
    // a rail moving between targets is not a fault in continuous mode
    assign fault_set       = monitored & ~rail_ok & {4{fault_armed}} &
                             ((mode == pg_pkg::PG_GATED) ? 4'hf : ~rail_ramping);
    assign sources_ok      = &(~monitored | rail_ok)
                             && !(pg_select[4] && die_warn_status)
                             && !irq[`PG_IRQ_OV] && !irq[`PG_IRQ_SD];

    always_ff @(posedge clock) begin
        if (rst)
            enable_q <= 4'h0;
        else
            enable_q <= monitored;
    end

    always_ff @(posedge clock) begin
        if (rst)
            rail_fault_latch <= 4'h0;
        else
            rail_fault_latch <= (rail_fault_latch & ~fault_clr) | fault_set;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // gating window and power-good state

    logic [31:0]           gate_count;
    logic                  next_pg_state;

    always_ff @(posedge clock) begin
        if (rst) begin
            phase      <= pg_pkg::PG_IDLE;
            gate_count <= 32'h0000_0000;
        end else begin
            case (phase)
                pg_pkg::PG_IDLE: begin
                    if (otp_load_done) begin
                        phase      <= pg_pkg::PG_GATING;
                        gate_count <= 32'(GATE_CYCLES);
                    end
                end
                pg_pkg::PG_GATING: begin
                    if (volt_change_req)
                        gate_count <= 32'(GATE_CYCLES);
                    else if (gate_count <= 32'h0000_0001)
                        phase <= pg_pkg::PG_WATCH;
                    else
                        gate_count <= gate_count - 32'h0000_0001;
                end
                pg_pkg::PG_WATCH: begin
                    if (volt_change_req) begin
                        phase      <= pg_pkg::PG_GATING;
                        gate_count <= 32'(GATE_CYCLES);
                    end
                end
                default: begin
                    phase <= pg_pkg::PG_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        next_pg_state = pg_state;
        if (otp_load_done) begin
            next_pg_state = 1'b1;
        end else if (phase == pg_pkg::PG_IDLE) begin
            next_pg_state = pg_state;
        end else if (mode == pg_pkg::PG_GATED) begin
            if (phase == pg_pkg::PG_WATCH)
                next_pg_state = sources_ok && !(|rail_fault_latch);
        end else begin
            next_pg_state = sources_ok
                            && !(|(monitored & rail_ramping))
                            && !(|enable_rise)
                            && !(pg_cfg[`PG_CFG_HOLD] && |rail_fault_latch);
        end
    end

    // glitches of the combining logic stop at this flop
    always_ff @(posedge clock) begin
        if (rst)
            pg_state <= 1'b0;
        else
            pg_state <= next_pg_state;
    end

    // open drain releases for the high level, pulls low otherwise
    always_comb begin
        if (pg_cfg[`PG_CFG_OD]) begin
            power_good_out = 1'b0;
            power_good_oe  = pg_state ^ pg_cfg[`PG_CFG_POL];
        end else begin
            power_good_out = ~(pg_state ^ pg_cfg[`PG_CFG_POL]);
            power_good_oe  = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port

    always_ff @(posedge clock) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else begin
            bus_rdata <= 8'h00;
            if (bus_req.rd) begin
                case (bus_req.addr)
                    `PG_ADDR_SELECT:    bus_rdata <= {3'h0, pg_select};
                    `PG_ADDR_WINDOW:    bus_rdata <= {4'h0, pg_window_sel};
                    `PG_ADDR_CFG:       bus_rdata <= {4'h0, pg_cfg};
                    `PG_ADDR_FAULT:     bus_rdata <= {4'h0, rail_fault_latch};
                    `PG_ADDR_LIMIT_SEL: bus_rdata <= limit_sel;
                    `PG_ADDR_IRQ:       bus_rdata <= {1'b0, irq};
                    `PG_ADDR_STATUS:    bus_rdata <= {sense.die_sd, sense.vana_ov, pg_state,
                                                      die_warn_status, sense.limit};
                    `PG_ADDR_MASK:      bus_rdata <= {3'h0, irq_mask};
                    `PG_ADDR_CONFIG:    bus_rdata <= {7'h00, die_warn_threshold};
                    default:            bus_rdata <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    otp_assert_a: assert property (otp_load_done |=> pg_state)
        else $error("power-good not asserted after otp load");

    gate_hold_a: assert property ((mode == pg_pkg::PG_GATED && phase == pg_pkg::PG_GATING
                                   && !otp_load_done) |=> $stable(pg_state))
        else $error("power-good changed inside gating window");

    irq_block_a: assert property ((irq[6:5] != 2'b00 && phase == pg_pkg::PG_WATCH
                                   && !otp_load_done) |=> !pg_state)
        else $error("power-good active with ov or shutdown pending");

    ramp_low_a: assert property ((mode == pg_pkg::PG_CONTINUOUS && phase != pg_pkg::PG_IDLE
                                  && |(monitored & rail_ramping) && !otp_load_done)
                                 |=> !pg_state)
        else $error("power-good active during ramp");

    enable_drop_a: assert property ((mode == pg_pkg::PG_CONTINUOUS
                                     && phase != pg_pkg::PG_IDLE && |enable_rise
                                     && !otp_load_done) |=> !pg_state)
        else $error("power-good not dropped on enable");

    fault_hold_a: assert property ((pg_cfg[`PG_CFG_HOLD] && |rail_fault_latch
                                    && phase == pg_pkg::PG_WATCH && !otp_load_done)
                                   |=> !pg_state)
        else $error("power-good active with fault pending");

    fault_latch_a: assert property (fault_set != 4'h0 |=>
                                    (rail_fault_latch & $past(fault_set)) == $past(fault_set))
        else $error("rail fault not latched");

    // without a clear in this cycle the bit must survive the next edge
    fault_keep_a: assert property ((rail_fault_latch[0] && !fault_clr[0])
                                   |=> rail_fault_latch[0])
        else $error("rail fault dropped without clear");

    limit_refuse_a: assert property ((irq[0] && irq_clr[0] && irq_active[0]) |=> irq[0])
        else $error("limit irq cleared while active");

    buck_limit_a: assert property (qualified[0] |=> irq[0] ##1 !irq_out_n || irq_mask[0])
        else $error("buck limit irq not raised");

    ldo_limit_a: assert property (qualified[3] |=> irq[3])
        else $error("ldo limit irq not raised");

    irq_pin_a: assert property (|(irq & {2'b11, ~irq_mask}) |=> !irq_out_n)
        else $error("irq pin high with unmasked irq");

    pin_drive_a: assert property (!pg_cfg[`PG_CFG_OD] |->
                                  power_good_out == ~(pg_state ^ pg_cfg[`PG_CFG_POL]))
        else $error("push-pull pin level wrong");

    window_a: assert property ((!pg_window_sel[0] && sense.uv_ok[0]) |-> rail_ok[0])
        else $error("undervoltage-only window ignored");

endmodule

/* shared/pg_consts.svh */
// constants of the power-good monitor: offsets, fields, resets, timing
// assumes inclusion by bare name from the design file
`ifndef PG_CONSTS_SVH
`define PG_CONSTS_SVH

`define PG_CLOCK_MHZ       200
`define PG_GATE_TIME_US    800
`define PG_LIMIT_TIME_US   20

`define PG_ADDR_SELECT     4'h0
`define PG_ADDR_WINDOW     4'h1
`define PG_ADDR_CFG        4'h2
`define PG_ADDR_FAULT      4'h3
`define PG_ADDR_LIMIT_SEL  4'h4
`define PG_ADDR_IRQ        4'h5
`define PG_ADDR_STATUS     4'h6
`define PG_ADDR_MASK       4'h7
`define PG_ADDR_CONFIG     4'h8

`define PG_CFG_POL         0
`define PG_CFG_OD          1
`define PG_CFG_MODE        2
`define PG_CFG_HOLD        3

`define PG_IRQ_WARN        4
`define PG_IRQ_OV          5
`define PG_IRQ_SD          6

`define PG_SELECT_RESET    5'h0f
`define PG_WINDOW_RESET    4'h0
`define PG_CFG_RESET       4'h1
`define PG_MASK_RESET      5'h00
`define PG_LIMIT_RESET     8'h00

`endif

/* shared/pg_pkg.sv */
// types shared by the power-good monitor and its bench
// assumes nothing beyond a SystemVerilog compiler
package pg_pkg;

    typedef enum logic [0:0] {
        PG_GATED      = 1'b0,
        PG_CONTINUOUS = 1'b1
    } pg_mode_t;

    typedef enum logic [1:0] {
        PG_IDLE   = 2'b00,
        PG_GATING = 2'b01,
        PG_WATCH  = 2'b10
    } pg_phase_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // analog comparator flags; rails ordered ldo1, ldo0, buck1, buck0
    typedef struct packed {
        logic       die_sd;
        logic       vana_ov;
        logic       die_warn;
        logic [3:0] limit;
        logic [3:0] ov_ok;
        logic [3:0] uv_ok;
    } sense_t;

endpackage

/* verification/pg_host_model.sv */
// host side of the power-good pin and the interrupt line
// assumes a pull-up on the power-good wire, as open-drain needs
`timescale 1ns/1ps

module pg_host_model (
    input  wire logic power_good_out,
    input  wire logic power_good_oe,
    input  wire logic irq_out_n,
    output logic      pg_level,
    output logic      irq_low
);
    // undriven wire floats up to the pull-up level
    assign pg_level = power_good_oe ? power_good_out : 1'b1;
    assign irq_low  = !irq_out_n;
endmodule

/* verification/tb_power_good_monitor.sv */
// bench for the power-good monitor: register tasks and pin checks
// assumes the host model resolves the power-good wire
`timescale 1ns/1ps
`include "pg_consts.svh"

module tb_power_good_monitor;
    logic             clock;
    logic             rst;
    pg_pkg::reg_req_t req;
    logic [7:0]       rdata;
    pg_pkg::sense_t   sense;
    logic [3:0]       en;
    logic [3:0]       ramp;
    logic             vchg;
    logic             otp_done;
    logic             otp_mode;
    logic [2:0]       lim0;
    logic [2:0]       lim1;
    logic             thr;
    logic             pg_out;
    logic             pg_oe;
    logic             irq_n;
    logic             pg_level;
    logic             irq_low;
    int               fail_count;
    int               n_checks;

    // short gate window keeps the gated runs brief
    power_good_monitor #(.GATE_CYCLES(50)) power_good_monitor_i (
        .clock(clock), .rst(rst), .bus_req(req), .bus_rdata(rdata),
        .sense_raw(sense), .rail_enable(en), .rail_ramping(ramp),
        .volt_change_req(vchg), .otp_load_done(otp_done), .otp_pg_mode(otp_mode),
        .buck0_limit_sel(lim0), .buck1_limit_sel(lim1), .die_warn_threshold(thr),
        .power_good_out(pg_out), .power_good_oe(pg_oe), .irq_out_n(irq_n));

    pg_host_model pg_host_model_i (
        .power_good_out(pg_out), .power_good_oe(pg_oe), .irq_out_n(irq_n),
        .pg_level(pg_level), .irq_low(irq_low));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic val_chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        val_chk(rdata, exp, "register");
    endtask

    // waits up to bound cycles for the level; bound 0 means it must hold now
    task automatic pin_chk(input logic irq, input logic exp, input int bound);
        int i;
        i = 0;
        while ((irq ? irq_low : pg_level) !== exp && i < bound) begin
            @(posedge clock);
            #1;
            i++;
        end
        val_chk({7'h00, irq ? irq_low : pg_level}, {7'h00, exp}, "pin");
    endtask

    task automatic boot(input logic mode);
        rst <= 1'b1;
        wt(6);
        rst <= 1'b0;
        // let the sense synchroniser fill before monitoring is armed
        wt(5);
        otp_mode <= mode;
        otp_done <= 1'b1;
        wt(1);
        otp_done <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        wt(60000);
        val_chk(8'h00, 8'h01, "timeout");
        conclude();
    end

    initial begin
        rst = 1'b1;
        req = '0;
        sense = 15'h00ff;
        en = 4'hf;
        ramp = 4'h0;
        vchg = 1'b0;
        otp_done = 1'b0;
        otp_mode = 1'b0;
        fail_count = 0;
        n_checks = 0;
        boot(1'b1);
        pin_chk(0, 1'b1, 4);
        rd_chk(`PG_ADDR_SELECT, 8'h0f);
        rd_chk(`PG_ADDR_CFG, 8'h05);
        rd_chk(`PG_ADDR_MASK, 8'h00);
        rd_chk(4'hf, 8'h00);
        sense.uv_ok[0] <= 1'b0;
        pin_chk(0, 1'b0, 10);
        sense.uv_ok[0] <= 1'b1;
        pin_chk(0, 1'b1, 10);
        rd_chk(`PG_ADDR_FAULT, 8'h01);
        wr(`PG_ADDR_FAULT, 8'h01);
        rd_chk(`PG_ADDR_FAULT, 8'h00);
        ramp <= 4'h2;
        pin_chk(0, 1'b0, 10);
        ramp <= 4'h0;
        pin_chk(0, 1'b1, 10);
        sense.ov_ok[1] <= 1'b0;
        wt(10);
        pin_chk(0, 1'b1, 0);
        wr(`PG_ADDR_WINDOW, 8'h02);
        pin_chk(0, 1'b0, 10);
        sense.ov_ok[1] <= 1'b1;
        pin_chk(0, 1'b1, 10);
        wr(`PG_ADDR_FAULT, 8'h02);
        wr(`PG_ADDR_SELECT, 8'h0e);
        en <= 4'hb;
        sense <= 15'h00fa;
        wt(10);
        pin_chk(0, 1'b1, 0);
        sense <= 15'h00ff;
        wt(10);
        en <= 4'hf;
        pin_chk(0, 1'b0, 4);
        pin_chk(0, 1'b1, 20);
        wr(`PG_ADDR_CFG, 8'h04);
        pin_chk(0, 1'b0, 4);
        rd_chk(`PG_ADDR_STATUS, 8'h20);
        wr(`PG_ADDR_CFG, 8'h07);
        pin_chk(0, 1'b1, 4);
        sense.vana_ov <= 1'b1;
        pin_chk(0, 1'b0, 10);
        pin_chk(1, 1'b1, 10);
        sense.vana_ov <= 1'b0;
        wt(10);
        pin_chk(0, 1'b0, 0);
        wr(`PG_ADDR_IRQ, 8'h20);
        pin_chk(0, 1'b1, 10);
        pin_chk(1, 1'b0, 4);
        wr(`PG_ADDR_CFG, 8'h0d);
        sense.uv_ok[3] <= 1'b0;
        pin_chk(0, 1'b0, 10);
        sense.uv_ok[3] <= 1'b1;
        wt(10);
        pin_chk(0, 1'b0, 0);
        wr(`PG_ADDR_FAULT, 8'h08);
        pin_chk(0, 1'b1, 10);
        sense.limit[0] <= 1'b1;
        wt(3990);
        pin_chk(1, 1'b0, 0);
        pin_chk(1, 1'b1, 30);
        rd_chk(`PG_ADDR_STATUS, 8'h21);
        wr(`PG_ADDR_IRQ, 8'h01);
        rd_chk(`PG_ADDR_IRQ, 8'h01);
        sense.limit[0] <= 1'b0;
        wt(20);
        wr(`PG_ADDR_IRQ, 8'h01);
        pin_chk(1, 1'b0, 4);
        wr(`PG_ADDR_MASK, 8'h08);
        sense.limit[3] <= 1'b1;
        wt(4030);
        rd_chk(`PG_ADDR_IRQ, 8'h08);
        pin_chk(1, 1'b0, 0);
        sense.limit[3] <= 1'b0;
        wr(`PG_ADDR_SELECT, 8'h1f);
        sense.die_warn <= 1'b1;
        wt(4010);
        rd_chk(`PG_ADDR_IRQ, 8'h18);
        pin_chk(0, 1'b0, 0);
        pin_chk(1, 1'b1, 4);
        sense.die_warn <= 1'b0;
        pin_chk(0, 1'b1, 10);
        wr(`PG_ADDR_IRQ, 8'h10);
        pin_chk(1, 1'b0, 4);
        wr(`PG_ADDR_LIMIT_SEL, 8'h53);
        wt(1);
        val_chk({5'h00, lim0}, 8'h03, "buck0 limit");
        val_chk({5'h00, lim1}, 8'h05, "buck1 limit");
        wr(`PG_ADDR_CONFIG, 8'h01);
        wt(1);
        val_chk({7'h00, thr}, 8'h01, "threshold");
        boot(1'b0);
        pin_chk(0, 1'b1, 4);
        sense.uv_ok[1] <= 1'b0;
        wt(30);
        pin_chk(0, 1'b1, 0);
        pin_chk(0, 1'b0, 40);
        rd_chk(`PG_ADDR_FAULT, 8'h02);
        sense.uv_ok[1] <= 1'b1;
        wt(10);
        pin_chk(0, 1'b0, 0);
        wr(`PG_ADDR_FAULT, 8'h02);
        pin_chk(0, 1'b1, 10);
        vchg <= 1'b1;
        wt(1);
        vchg <= 1'b0;
        sense.uv_ok[1] <= 1'b0;
        wt(30);
        pin_chk(0, 1'b1, 0);
        conclude();
    end
endmodule
